/* File: pmr_pkg.sv */
// Purpose: Shared constants of the power and buffer status register bank
// Assumes: 100 MHz pclk, 32-bit APB data, byte addresses
// Notes:   Every offset, field position and timing count lives here, with most reset values
package pmr_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] RX_OCC_OFS  = 12'h018;
	localparam logic [ADDR_W-1:0] TX_FREE_OFS = 12'h01c;
	localparam logic [ADDR_W-1:0] PWR_CTL_OFS = 12'h020;

	// ---------------------------------------------------------------
	// Field positions of power_wake_control
	// ---------------------------------------------------------------
	localparam int CLR_FLAGS_BIT = 9;
	localparam int CLR_EN_BIT    = 8;
	localparam int READY_BIT     = 7;
	localparam int SLEEP_HI      = 6;
	localparam int SLEEP_LO      = 5;
	localparam int TRANSCEIVER_RESET_PULSE_BIT   = 4;
	localparam int LAN_EN_BIT    = 3;
	localparam int ENERGY_DETECT_WAKE_ENABLE_BIT     = 2;
	localparam int CAUSE_HI      = 1;
	localparam int CAUSE_LO      = 0;

	// ---------------------------------------------------------------
	// Reset values and encodings
	// ---------------------------------------------------------------
	localparam int LEVEL_W = 16;
	localparam logic [LEVEL_W-1:0] RX_OCC_RESET  = 16'h0000;
	localparam logic [LEVEL_W-1:0] TX_FREE_RESET = 16'h2000;
	localparam logic               CLR_FLAGS_RESET = 1'b0;
	localparam logic               CLR_EN_RESET    = 1'b1;
	localparam logic [1:0]         SLEEP_TWO       = 2'h2;
	localparam logic [1:0]         CAUSE_NONE      = 2'h0;
	localparam logic [31:0]        ZERO_WORD       = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned TRANSCEIVER_RESET_PULSE_HOLD_MS = 2;
	localparam int unsigned TRANSCEIVER_RESET_PULSE_CYCLES  =
		(TRANSCEIVER_RESET_PULSE_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Word-aligned byte count for frame data ending mid-word
	function automatic logic [LEVEL_W-1:0] round_to_word(input logic [LEVEL_W-1:0] len);
		round_to_word = (len + 16'h0003) & 16'hfffc;
	endfunction

endpackage

/* File: pmr_level_if.sv */
// Purpose: Carries one buffer level counter's updates and value
// Assumes: Single pclk domain
// Notes:   owner side keeps the count, user side feeds it
`timescale 1ns/1ps
interface pmr_level_if #(parameter int WIDTH = 16);
	logic             add;
	logic [WIDTH-1:0] add_len;
	logic             sub;
	logic [WIDTH-1:0] sub_len;
	logic [WIDTH-1:0] level;

	modport owner (input add, input add_len, input sub, input sub_len, output level);
	modport user  (output add, output add_len, output sub, output sub_len, input level);
endinterface

/* File: pmr_level_count.sv */
// Purpose: Byte level counter of one data buffer
// Assumes: add and sub are one-cycle pulses in the pclk domain
// Notes:   ROUND rounds each addition up to a whole 32-bit word
`timescale 1ns/1ps
module pmr_level_count #(
	parameter int                                  WIDTH       = 16,
	parameter bit                                  ROUND       = 1'b0,
	parameter logic [pmr_pkg::LEVEL_W-1:0]         RESET_LEVEL = pmr_pkg::RX_OCC_RESET
) (
	input wire logic        pclk,
	input wire logic        presetn,
	pmr_level_if.owner      lvl
);
	logic [WIDTH-1:0] add_amt;
	logic [WIDTH-1:0] next_level;

	always_comb
	begin
		add_amt = ROUND ? pmr_pkg::round_to_word(lvl.add_len) : lvl.add_len;
		next_level = lvl.level;
		if (lvl.add)
			next_level = next_level + add_amt;
		if (lvl.sub)
			next_level = next_level - lvl.sub_len;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lvl.level <= RESET_LEVEL;
		else
			lvl.level <= next_level;
	end

	round_add_a: assert property (@(posedge pclk) disable iff (!presetn)
		(lvl.add && !lvl.sub) |=>
			lvl.level == $past(lvl.level) + (ROUND ? pmr_pkg::round_to_word($past(lvl.add_len))
				: $past(lvl.add_len)))
		else $error("buffer level did not grow by the rounded length");
endmodule

/* File: pmr_phy_reset_timer.sv */
// Purpose: Holds the transceiver reset for a fixed number of cycles
// Assumes: start is a one-cycle pulse
// Notes:   A start while busy is dropped, so the hold cannot be stretched
`timescale 1ns/1ps
module pmr_phy_reset_timer #(
	parameter int unsigned HOLD_CYCLES = pmr_pkg::TRANSCEIVER_RESET_PULSE_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	output logic      busy
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

	logic [CW-1:0] count;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy  <= 1'b0;
			count <= '0;
		end
		else if (!busy && start)
		begin
			busy  <= 1'b1;
			count <= LAST;
		end
		else if (busy)
		begin
			if (count == '0)
				busy <= 1'b0;
			else
				count <= count - 1'b1;
		end
	end

	restart_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		(busy && start && count != '0) |=> (busy && count == $past(count) - 1'b1))
		else $error("start while busy disturbed the reset hold");
endmodule

/* File: pmr_regs.sv */
// Purpose: Buffer status and power management control registers on APB
// Assumes: All inputs synchronous to pclk; event inputs are one-cycle pulses
// Notes:   One wait state per APB access; unmapped addresses answer pslverr
//
// How it works
// - rx_buffer_occupancy bits 15:0 give bytes held in receive buffer, reset zero.
// - Each received frame adds its length rounded up to a whole word.
// - tx_buffer_free_space bits 15:0 give free transmit bytes, reset 2000h.
// - Bit 9 set: lan wake resume completion clears MAC wake frame/magic flags.
// - Bit 9 set: such a resume also clears the upper wake cause bit.
// - Only wake frame or magic packet resumes trigger that clearing.
// - Bit 8 set (reset 1): remote resume clears all wake enables.
// - Read-only bit 7 shows normal state with configuration done; resets 0.
// - Without PHY clocks, ready waits for the watchdog expiry.
// - Bits 6:5 pick the sleep state on suspend, reset 10b.
// - Deconfiguration forces the sleep selection back to 10b.
// - Writing 1 to bit 4 resets the PHY for 2 ms, then self-clears.
// - Writes to bit 4 are ignored while it reads high.
// - USB transfers get NAK until the PHY reset completes.
// - Bit 3 enables LAN wake, bit 2 energy detect wake; both reset 0.
// - Bits 1:0 record wake cause: none, energy, LAN, multiple; reset 00.
// - Writing 1 to either wake cause bit clears both.
// - A wake cause records only sources enabled before reduced power entry.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module pmr_regs #(
	parameter int unsigned TRANSCEIVER_RESET_PULSE_CYCLES = pmr_pkg::TRANSCEIVER_RESET_PULSE_CYCLES,
	parameter int          LEVEL_W        = pmr_pkg::LEVEL_W
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [pmr_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic      [31:0]                prdata,
	output logic                            pslverr,
	input  wire logic                       rx_frame_store,
	input  wire logic [LEVEL_W-1:0]         rx_frame_len,
	input  wire logic                       rx_drain,
	input  wire logic [LEVEL_W-1:0]         rx_drain_len,
	input  wire logic                       tx_load,
	input  wire logic [LEVEL_W-1:0]         tx_load_len,
	input  wire logic                       tx_release,
	input  wire logic [LEVEL_W-1:0]         tx_release_len,
	input  wire logic                       device_normal,
	input  wire logic                       hw_config_done,
	input  wire logic                       phy_clocks_present,
	input  wire logic                       watchdog_expired,
	input  wire logic                       deconfigure,
	input  wire logic                       in_reduced_power,
	input  wire logic                       energy_event,
	input  wire logic                       lan_event,
	input  wire logic                       resume_done,
	input  wire logic                       resume_remote,
	input  wire logic                       resume_by_lan_frame,
	output logic                            phy_reset_out,
	output logic                            usb_nak,
	output logic      [1:0]                 sleep_select,
	output logic                            lan_wake_enable,
	output logic                            energy_detect_wake_enable,
	output logic                            mac_wake_flags_clear
);
	// ---------------------------------------------------------------
	// Buffer level counters
	// ---------------------------------------------------------------
	pmr_level_if #(.WIDTH(LEVEL_W)) rx_lvl ();
	pmr_level_if #(.WIDTH(LEVEL_W)) tx_lvl ();

	assign rx_lvl.add     = rx_frame_store;
	assign rx_lvl.add_len = rx_frame_len;
	assign rx_lvl.sub     = rx_drain;
	assign rx_lvl.sub_len = rx_drain_len;
	// Free space grows when the MAC releases bytes and shrinks on host loads
	assign tx_lvl.add     = tx_release;
	assign tx_lvl.add_len = tx_release_len;
	assign tx_lvl.sub     = tx_load;
	assign tx_lvl.sub_len = tx_load_len;

	pmr_level_count #(
		.WIDTH       (LEVEL_W),
		.ROUND       (1'b1),
		.RESET_LEVEL (pmr_pkg::RX_OCC_RESET)
	) u_rx_level (
		.pclk    (pclk),
		.presetn (presetn),
		.lvl     (rx_lvl)
	);

	pmr_level_count #(
		.WIDTH       (LEVEL_W),
		.ROUND       (1'b0),
		.RESET_LEVEL (pmr_pkg::TX_FREE_RESET)
	) u_tx_level (
		.pclk    (pclk),
		.presetn (presetn),
		.lvl     (tx_lvl)
	);

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic        wr_done;
	logic        wr_ctl;
	logic        hit_ctl;
	logic        hit_any;
	logic        resume_clears_wake_flags;
	logic        resume_clears_wake_enables;
	logic        device_ready;
	logic [1:0]  wake_cause;
	logic [31:0] ctl_word;
	logic [31:0] next_prdata;

	assign hit_ctl = (paddr == pmr_pkg::PWR_CTL_OFS);
	assign hit_any = hit_ctl || (paddr == pmr_pkg::RX_OCC_OFS) || (paddr == pmr_pkg::TX_FREE_OFS);
	// A write takes effect only at the completing edge of the access phase
	assign wr_done = psel && penable && pready && pwrite;
	assign wr_ctl  = wr_done && hit_ctl;

	always_comb
	begin
		ctl_word = pmr_pkg::ZERO_WORD;
		ctl_word[pmr_pkg::CLR_FLAGS_BIT] = resume_clears_wake_flags;
		ctl_word[pmr_pkg::CLR_EN_BIT] = resume_clears_wake_enables;
		ctl_word[pmr_pkg::READY_BIT] = device_ready;
		ctl_word[pmr_pkg::SLEEP_HI:pmr_pkg::SLEEP_LO] = sleep_select;
		ctl_word[pmr_pkg::TRANSCEIVER_RESET_PULSE_BIT] = phy_reset_out;
		ctl_word[pmr_pkg::LAN_EN_BIT] = lan_wake_enable;
		ctl_word[pmr_pkg::ENERGY_DETECT_WAKE_ENABLE_BIT] = energy_detect_wake_enable;
		ctl_word[pmr_pkg::CAUSE_HI:pmr_pkg::CAUSE_LO] = wake_cause;
		next_prdata = pmr_pkg::ZERO_WORD;
		if (paddr == pmr_pkg::RX_OCC_OFS)
			next_prdata[LEVEL_W-1:0] = rx_lvl.level;
		else if (paddr == pmr_pkg::TX_FREE_OFS)
			next_prdata[LEVEL_W-1:0] = tx_lvl.level;
		else if (hit_ctl)
			next_prdata = ctl_word;
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && penable && !pready;
	end

	// Read data and error are captured in the setup cycle and stand to the end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= pmr_pkg::ZERO_WORD;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata  <= pwrite ? pmr_pkg::ZERO_WORD : next_prdata;
			pslverr <= !hit_any;
		end
	end

	// ---------------------------------------------------------------
	// Resume options and ready indication
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resume_clears_wake_flags   <= pmr_pkg::CLR_FLAGS_RESET;
			resume_clears_wake_enables <= pmr_pkg::CLR_EN_RESET;
		end
		else if (wr_ctl)
		begin
			resume_clears_wake_flags   <= pwdata[pmr_pkg::CLR_FLAGS_BIT];
			resume_clears_wake_enables <= pwdata[pmr_pkg::CLR_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			device_ready <= 1'b0;
		else
			device_ready <= device_normal && hw_config_done &&
				(phy_clocks_present || watchdog_expired);
	end

	// ---------------------------------------------------------------
	// Sleep state selection
	// ---------------------------------------------------------------
	// Software keeps this at state two while unconfigured; no check is made here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sleep_select <= pmr_pkg::SLEEP_TWO;
		else if (deconfigure)
			sleep_select <= pmr_pkg::SLEEP_TWO;
		else if (wr_ctl)
			sleep_select <= pwdata[pmr_pkg::SLEEP_HI:pmr_pkg::SLEEP_LO];
	end

	// ---------------------------------------------------------------
	// Transceiver reset
	// ---------------------------------------------------------------
	logic phy_start;

	assign phy_start = wr_ctl && pwdata[pmr_pkg::TRANSCEIVER_RESET_PULSE_BIT];

	pmr_phy_reset_timer #(
		.HOLD_CYCLES (TRANSCEIVER_RESET_PULSE_CYCLES)
	) u_phy_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (phy_start),
		.busy    (phy_reset_out)
	);

	// Set from the write itself so it rises at the same edge as the hold starts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			usb_nak <= 1'b0;
		else
			usb_nak <= phy_start || (phy_reset_out && !(usb_nak && !phy_reset_out));
	end

	// ---------------------------------------------------------------
	// Wake enables and wake cause
	// ---------------------------------------------------------------
	logic remote_clear;
	logic flag_clear;
	logic was_reduced;
	logic energy_armed;
	logic lan_armed;
	logic [1:0] cause_set;

	assign remote_clear = resume_done && resume_remote && resume_clears_wake_enables;
	assign flag_clear = resume_done && resume_by_lan_frame && resume_clears_wake_flags;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lan_wake_enable           <= 1'b0;
			energy_detect_wake_enable <= 1'b0;
		end
		else if (remote_clear)
		begin
			lan_wake_enable           <= 1'b0;
			energy_detect_wake_enable <= 1'b0;
		end
		else if (wr_ctl)
		begin
			lan_wake_enable           <= pwdata[pmr_pkg::LAN_EN_BIT];
			energy_detect_wake_enable <= pwdata[pmr_pkg::ENERGY_DETECT_WAKE_ENABLE_BIT];
		end
	end

	// Enables are frozen on entry so later writes cannot arm a source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			was_reduced  <= 1'b0;
			energy_armed <= 1'b0;
			lan_armed    <= 1'b0;
		end
		else
		begin
			was_reduced <= in_reduced_power;
			if (in_reduced_power && !was_reduced)
			begin
				energy_armed <= energy_detect_wake_enable;
				lan_armed    <= lan_wake_enable;
			end
		end
	end

	assign cause_set[0] = energy_event && energy_armed;
	assign cause_set[1] = lan_event && lan_armed;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_cause <= pmr_pkg::CAUSE_NONE;
		else
		begin
			if (wr_ctl && (pwdata[pmr_pkg::CAUSE_HI:pmr_pkg::CAUSE_LO] != 2'h0))
				wake_cause <= cause_set;
			else if (flag_clear)
				wake_cause <= {cause_set[1], wake_cause[0] | cause_set[0]};
			else
				wake_cause <= wake_cause | cause_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mac_wake_flags_clear <= 1'b0;
		else
			mac_wake_flags_clear <= flag_clear;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	phy_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(phy_reset_out) |-> phy_reset_out[*8])
		else $error("transceiver reset released too early");

	nak_cover_a: assert property (@(posedge pclk) disable iff (!presetn)
		phy_reset_out |-> usb_nak)
		else $error("USB transfer not refused during transceiver reset");

	ready_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		device_ready |-> $past(device_normal && hw_config_done &&
			(phy_clocks_present || watchdog_expired)))
		else $error("ready shown without normal state or PHY clocks");

	deconf_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
		deconfigure |=> sleep_select == pmr_pkg::SLEEP_TWO)
		else $error("deconfiguration did not restore sleep state two");

	cause_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctl && pwdata[1:0] != 2'h0 && !energy_event && !lan_event)
			|=> wake_cause == pmr_pkg::CAUSE_NONE)
		else $error("write of one did not clear wake cause");

	cause_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(energy_event && !energy_armed && !lan_event && !wr_ctl && !flag_clear)
			|=> $stable(wake_cause))
		else $error("unarmed energy event changed wake cause");

	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(resume_done && !resume_by_lan_frame) |=> !mac_wake_flags_clear)
		else $error("non-LAN resume cleared MAC wake flags");

	enable_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		remote_clear |=> (!lan_wake_enable && !energy_detect_wake_enable))
		else $error("remote resume left wake enables set");

	reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && !pwrite) |-> prdata[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");
endmodule

/* File: power_mgmt_fifo_status_regs_bench.sv */
// Purpose: Self-checking bench of the buffer status and power control registers
// Assumes: APB master driven on rising edges; shortened transceiver reset hold
// Notes:   Table rows first, then hand-written event, reset and corner cases
`timescale 1ns/1ps
module power_mgmt_fifo_status_regs_bench;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int unsigned HOLD  = 16;
	localparam int          LIMIT = 20000;
	typedef struct packed {logic wr; logic [11:0] a; logic [31:0] wd, exp; logic err;} pmr_row_t;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, phy_reset_out, usb_nak, mac_wake_flags_clear;
	logic [1:0]  sleep_select;
	logic        lan_wake_enable, energy_detect_wake_enable;
	logic        rx_frame_store = 1'b0, rx_drain = 1'b0, tx_load = 1'b0, tx_release = 1'b0;
	logic [15:0] rx_frame_len = 16'h0000, rx_drain_len = 16'h0000;
	logic [15:0] tx_load_len = 16'h0000, tx_release_len = 16'h0000;
	logic        device_normal = 1'b0, hw_config_done = 1'b0, phy_clocks_present = 1'b1;
	logic        watchdog_expired = 1'b0, deconfigure = 1'b0, in_reduced_power = 1'b0;
	logic        energy_event = 1'b0, lan_event = 1'b0, resume_done = 1'b0;
	logic        resume_remote = 1'b0, resume_by_lan_frame = 1'b0;
	int          n_mismatch = 0, num_checks = 0, cycles = 0, hi_cnt = 0, nak_miss = 0;
	logic [31:0] r;
	logic        e;
	pmr_row_t    rows [11] = '{
		'{1'b0, 12'h018, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 12'h01c, 32'h0000_0000, 32'h0000_2000, 1'b0},
		'{1'b0, 12'h020, 32'h0000_0000, 32'h0000_0140, 1'b0},
		'{1'b1, 12'h018, 32'hffff_ffff, 32'h0000_0000, 1'b0},
		'{1'b0, 12'h018, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b1, 12'h01c, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 12'h01c, 32'h0000_0000, 32'h0000_2000, 1'b0},
		'{1'b1, 12'h020, 32'hffff_ffec, 32'h0000_0000, 1'b0},
		'{1'b0, 12'h020, 32'h0000_0000, 32'h0000_036c, 1'b0},
		'{1'b1, 12'h024, 32'h0000_0001, 32'h0000_0000, 1'b1},
		'{1'b0, 12'h100, 32'h0000_0000, 32'h0000_0000, 1'b1}};

	pmr_regs #(.TRANSCEIVER_RESET_PULSE_CYCLES(HOLD)) u_pmr_regs (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .rx_frame_store, .rx_frame_len, .rx_drain, .rx_drain_len, .tx_load,
		.tx_load_len, .tx_release, .tx_release_len, .device_normal, .hw_config_done,
		.phy_clocks_present, .watchdog_expired, .deconfigure, .in_reduced_power,
		.energy_event, .lan_event, .resume_done, .resume_remote, .resume_by_lan_frame,
		.phy_reset_out, .usb_nak, .sleep_select, .lan_wake_enable,
		.energy_detect_wake_enable, .mac_wake_flags_clear);

	always #5 pclk = ~pclk;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task conclude();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (phy_reset_out === 1'b1) hi_cnt++;
		if (phy_reset_out === 1'b1 && usb_nak !== 1'b1) nak_miss++;
		if (cycles == LIMIT)
		begin
			n_mismatch++;
			conclude();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [31:0] d);
		apb(1'b1, 12'h020, d, r, e);
	endtask

	task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r & m, x);
	endtask

	// Flag pulse is looked at in the one cycle after the resume is sampled
	task resume(input logic frame, input logic remote, input logic flag);
		@(posedge pclk);
		resume_done <= 1'b1;
		resume_by_lan_frame <= frame;
		resume_remote <= remote;
		@(posedge pclk);
		resume_done <= 1'b0;
		@(posedge pclk);
		chk({31'h0, mac_wake_flags_clear}, {31'h0, flag});
	endtask

	task wake(input logic en, input logic ln);
		@(posedge pclk);
		energy_event <= en;
		lan_event <= ln;
		@(posedge pclk);
		energy_event <= 1'b0;
		lan_event <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].wr, rows[i].a, rows[i].wd, r, e);
			if (!rows[i].wr) chk(r, rows[i].exp);
			chk({31'h0, e}, {31'h0, rows[i].err});
		end
		wr(32'h0000_0000);
		// Back-to-back frames of 5 and 8 bytes, then a 3-byte drain
		@(posedge pclk);
		rx_frame_store <= 1'b1;
		rx_frame_len <= 16'h0005;
		tx_load <= 1'b1;
		tx_load_len <= 16'h0100;
		@(posedge pclk);
		rx_frame_len <= 16'h0008;
		tx_load <= 1'b0;
		tx_release <= 1'b1;
		tx_release_len <= 16'h0010;
		@(posedge pclk);
		rx_frame_store <= 1'b0;
		tx_release <= 1'b0;
		rx_drain <= 1'b1;
		rx_drain_len <= 16'h0003;
		@(posedge pclk);
		rx_drain <= 1'b0;
		rchk(12'h018, 32'hffff_ffff, 32'h0000_000d);
		rchk(12'h01c, 32'hffff_ffff, 32'h0000_1f10);
		device_normal <= 1'b1;
		rchk(12'h020, 32'h0000_0080, 32'h0000_0000);
		hw_config_done <= 1'b1;
		phy_clocks_present <= 1'b0;
		rchk(12'h020, 32'h0000_0080, 32'h0000_0000);
		watchdog_expired <= 1'b1;
		rchk(12'h020, 32'h0000_0080, 32'h0000_0080);
		hi_cnt = 0;
		wr(32'h0000_0010);
		rchk(12'h020, 32'h0000_0010, 32'h0000_0010);
		wr(32'h0000_0010);
		for (int k = 0; k < 100 && phy_reset_out === 1'b1; k++) @(posedge pclk);
		chk(32'(hi_cnt), HOLD);
		@(posedge pclk);
		chk({31'h0, usb_nak}, 32'h0000_0000);
		chk(32'(nak_miss), 32'h0000_0000);
		rchk(12'h020, 32'h0000_0010, 32'h0000_0000);
		// Enables off before entry: events must leave no trace
		in_reduced_power <= 1'b1;
		repeat (2) @(posedge pclk);
		wake(1'b1, 1'b0);
		wake(1'b0, 1'b1);
		rchk(12'h020, 32'h0000_0003, 32'h0000_0000);
		in_reduced_power <= 1'b0;
		wr(32'h0000_000c);
		// Register fields settle after the completing edge
		@(posedge pclk);
		chk({30'h0, lan_wake_enable, energy_detect_wake_enable}, 32'h0000_0003);
		in_reduced_power <= 1'b1;
		repeat (2) @(posedge pclk);
		wake(1'b1, 1'b0);
		rchk(12'h020, 32'h0000_0003, 32'h0000_0001);
		wake(1'b0, 1'b1);
		rchk(12'h020, 32'h0000_0003, 32'h0000_0003);
		wr(32'h0000_000d);
		rchk(12'h020, 32'h0000_0003, 32'h0000_0000);
		wake(1'b1, 1'b1);
		in_reduced_power <= 1'b0;
		wr(32'h0000_010c);
		resume(1'b1, 1'b0, 1'b0);
		rchk(12'h020, 32'h0000_030f, 32'h0000_010f);
		wr(32'h0000_030c);
		resume(1'b1, 1'b0, 1'b1);
		rchk(12'h020, 32'h0000_030f, 32'h0000_030d);
		resume(1'b0, 1'b1, 1'b0);
		rchk(12'h020, 32'h0000_030f, 32'h0000_0301);
		wr(32'h0000_0020);
		@(posedge pclk);
		chk({30'h0, sleep_select}, 32'h0000_0001);
		@(posedge pclk);
		deconfigure <= 1'b1;
		@(posedge pclk);
		deconfigure <= 1'b0;
		@(posedge pclk);
		// Deconfiguration has put the sleep selection back to state two
		chk({30'h0, sleep_select}, 32'h0000_0002);
		rchk(12'h020, 32'h0000_0060, 32'h0000_0040);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(12'h018, 32'hffff_ffff, 32'h0000_0000);
		rchk(12'h01c, 32'hffff_ffff, 32'h0000_2000);
		rchk(12'h020, 32'hffff_ff7f, 32'h0000_0140);
		conclude();
	end
endmodule
